//--- logic/fsw_params.svh
// Purpose: constants for the flash self-program write block
// Assumes: byte-wide register port, 100 MHz core clock
// Notes: offsets are local choices
`ifndef FSW_PARAMS_SVH
`define FSW_PARAMS_SVH
`define FSW_ADDR_PTR_UPPER 4'h0
`define FSW_ADDR_PTR_HIGH 4'h1
`define FSW_ADDR_PTR_LOW 4'h2
`define FSW_ADDR_LATCH 4'h3
`define FSW_ADDR_KEY 4'h4
`define FSW_ADDR_CONTROL 4'h5
`define FSW_ADDR_STORE 4'h6
`define FSW_ADDR_IRQ_STATUS 4'h7
`define FSW_ADDR_IRQ_MASK 4'h8
`define FSW_ADDR_HOLD_INDEX 4'h9
`define FSW_ADDR_HOLD_DATA 4'ha
`define FSW_CTL_ERASE 4
`define FSW_CTL_FAULT 3
`define FSW_CTL_ENABLE 2
`define FSW_CTL_START 1
`define FSW_CTL_MASK 8'h1e
`define FSW_PTR_UPPER_MASK 8'h3f
`define FSW_KEY_FIRST 8'h55
`define FSW_KEY_SECOND 8'haa
`define FSW_HOLD_COUNT 64
`define FSW_CLK_MHZ 100
`define FSW_WRITE_TIME_US 2800
`define FSW_WRITE_CYCLES (`FSW_WRITE_TIME_US * `FSW_CLK_MHZ)
`define FSW_IRQ_DONE 0
`define FSW_IRQ_FAULT 1
`endif

//--- logic/fsw_pkg.sv
// Purpose: types for the flash self-program write block
// Assumes: nothing
// Notes: constants live in fsw_params.svh
package fsw_pkg;
    typedef enum logic [1:0] {FSW_IDLE, FSW_KEY1, FSW_ARMED} fsw_key_t;
    typedef enum logic [1:0] {FSW_READY, FSW_PROGRAM, FSW_ERASE} fsw_cycle_t;
endpackage

//--- logic/fsw_unlock.sv
// Purpose: unlock key sequence detector
// Assumes: one strobe per register access
// Notes: any other access between key writes drops the sequence
`timescale 1ns/1ps
`include "fsw_params.svh"
module fsw_unlock
    import fsw_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic anyAccess,
    input wire logic keyWrite,
    input wire logic [7:0] keyData,
    input wire logic consume,
    output logic armed
);
    typedef struct packed {
        fsw_key_t state;
    } fsw_unlock_state_t;
    fsw_unlock_state_t cur;
    fsw_unlock_state_t next_cur;

    always_comb begin
        next_cur = cur;
        if (consume) begin
            next_cur.state = FSW_IDLE;
        end else if (anyAccess) begin
            case (cur.state)
                FSW_IDLE: begin
                    if (keyWrite && keyData == `FSW_KEY_FIRST) begin
                        next_cur.state = FSW_KEY1;
                    end
                end
                FSW_KEY1: begin
                    if (keyWrite && keyData == `FSW_KEY_SECOND) begin
                        next_cur.state = FSW_ARMED;
                    end else if (keyWrite && keyData == `FSW_KEY_FIRST) begin
                        next_cur.state = FSW_KEY1;
                    end else begin
                        next_cur.state = FSW_IDLE;
                    end
                end
                FSW_ARMED: begin
                    // only the very next access may start a cycle
                    next_cur.state = FSW_IDLE;
                end
                default: next_cur.state = FSW_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            cur <= '{state: FSW_IDLE};
        end else begin
            cur <= next_cur;
        end
    end

    assign armed = (cur.state == FSW_ARMED);

    chk_key_order: assert property (@(posedge core_clk) disable iff (reset)
        $rose(armed) |-> $past(keyWrite) && $past(keyData) == `FSW_KEY_SECOND)
        else $error("unlock armed without second key");
    cov_armed: cover property (@(posedge core_clk) disable iff (reset) $rose(armed));
endmodule

//--- logic/fsw_timer.sv
// Purpose: internal programming timer for long writes
// Assumes: start is a single-cycle pulse while idle
// Notes: length is a parameter so simulation can shorten it
`timescale 1ns/1ps
`include "fsw_params.svh"
module fsw_timer #(
    parameter int unsigned CYCLES = `FSW_WRITE_CYCLES
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic start,
    output logic busy,
    output logic done
);
    typedef struct packed {
        logic [31:0] count;
        logic busy;
        logic done;
    } fsw_timer_state_t;
    fsw_timer_state_t cur;
    fsw_timer_state_t next_cur;

    always_comb begin
        next_cur = cur;
        next_cur.done = 1'b0;
        if (cur.busy) begin
            if (cur.count == 32'h1) begin
                next_cur.busy = 1'b0;
                next_cur.done = 1'b1;
            end
            next_cur.count = cur.count - 32'h1;
        end else if (start) begin
            next_cur.busy = 1'b1;
            next_cur.count = 32'(CYCLES);
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign busy = cur.busy;
    assign done = cur.done;

    chk_timer_done: assert property (@(posedge core_clk) disable iff (reset)
        done |-> !busy && $past(busy))
        else $error("timer done without a running cycle");
endmodule

//--- logic/fsw_top.sv
// Purpose: flash self-program write controller with holding registers
// Assumes: byte register port, read data one cycle after read strobe
// Notes: the flash array itself lies outside; commands leave on ports
// How it works
// - one cycle programs sixty-four held bytes
// - pre-increment store bumps pointer then latches
// - enable bit must be set to program
// - keys 55h then 0AAh precede start
// - start after unlock stalls the cpu
// - erase bit selects row erase instead
// - fault flag marks operations cut by a fault reset
// - pointer is twenty-two bits in three bytes
// - key register stores nothing
// - holding registers survive a completed cycle
// - erase uses pointer bits 21 to 10
// - internal timer ends each long cycle
//
// Our own choices: the register addresses and strobed register access.
`timescale 1ns/1ps
`include "fsw_params.svh"
module fsw_top
    import fsw_pkg::*;
#(
    parameter int unsigned WRITE_CYCLES = `FSW_WRITE_CYCLES
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic faultReset,
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWriteData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regReadData,
    output logic cpuStall,
    output logic flashProgram,
    output logic flashErase,
    output logic [21:0] flashAddr,
    output logic [7:0] flashData,
    output logic [5:0] flashDataIndex,
    output logic irq
);
    typedef struct packed {
        logic [21:0] tablePointer;
        logic [7:0] tableLatchByte;
        logic eraseSelect;
        logic programFaultFlag;
        logic programEnable;
        logic writeStart;
        fsw_cycle_t cycle;
        logic [21:0] cycleAddr;
        logic faultPending;
        logic [1:0] irqStatus;
        logic [1:0] irqMask;
        logic [5:0] holdIndex;
        logic [7:0] readData;
        logic [`FSW_HOLD_COUNT-1:0][7:0] holding;
    } fsw_top_state_t;
    fsw_top_state_t cur;
    fsw_top_state_t next_cur;

    logic armed;
    logic timerBusy;
    logic timerDone;
    logic startCycle;
    logic wrCtl;

    function automatic logic [7:0] ctlByte(input fsw_top_state_t s);
        logic [7:0] b;
        b = 8'h00;
        b[`FSW_CTL_ERASE] = s.eraseSelect;
        b[`FSW_CTL_FAULT] = s.programFaultFlag;
        b[`FSW_CTL_ENABLE] = s.programEnable;
        b[`FSW_CTL_START] = s.writeStart;
        return b & `FSW_CTL_MASK;
    endfunction

    // the store path uses the incremented pointer twice
    function automatic logic [21:0] ptrNext(input logic [21:0] p);
        return p + 22'h1;
    endfunction

    assign wrCtl = regWrite && regAddr == `FSW_ADDR_CONTROL;
    // start only with enable set and keys directly before
    assign startCycle = wrCtl && regWriteData[`FSW_CTL_START] && regWriteData[`FSW_CTL_ENABLE]
        && armed && cur.cycle == FSW_READY;

    fsw_unlock u_unlock (
        .core_clk(core_clk),
        .reset(reset),
        .anyAccess(regWrite || regRead),
        .keyWrite(regWrite && regAddr == `FSW_ADDR_KEY),
        .keyData(regWriteData),
        .consume(startCycle),
        .armed(armed)
    );

    fsw_timer #(.CYCLES(WRITE_CYCLES)) u_timer (
        .core_clk(core_clk),
        .reset(reset),
        .start(startCycle),
        .busy(timerBusy),
        .done(timerDone)
    );

    always_comb begin
        next_cur = cur;
        if (regWrite) begin
            case (regAddr)
                `FSW_ADDR_PTR_UPPER: begin
                    next_cur.tablePointer[21:16] = regWriteData[5:0];
                end
                `FSW_ADDR_PTR_HIGH: next_cur.tablePointer[15:8] = regWriteData;
                `FSW_ADDR_PTR_LOW: next_cur.tablePointer[7:0] = regWriteData;
                `FSW_ADDR_LATCH: next_cur.tableLatchByte = regWriteData;
                `FSW_ADDR_STORE: begin
                    // pre-increment, then short write into holding register
                    next_cur.tablePointer = ptrNext(cur.tablePointer);
                    next_cur.holding[6'(ptrNext(cur.tablePointer))] = cur.tableLatchByte;
                end
                `FSW_ADDR_CONTROL: begin
                    next_cur.eraseSelect = regWriteData[`FSW_CTL_ERASE];
                    next_cur.programEnable = regWriteData[`FSW_CTL_ENABLE];
                    if (!regWriteData[`FSW_CTL_FAULT]) begin
                        next_cur.programFaultFlag = 1'b0;
                    end
                end
                `FSW_ADDR_IRQ_STATUS: next_cur.irqStatus = cur.irqStatus & ~regWriteData[1:0];
                `FSW_ADDR_IRQ_MASK: next_cur.irqMask = regWriteData[1:0];
                `FSW_ADDR_HOLD_INDEX: next_cur.holdIndex = regWriteData[5:0];
                default: begin
                end
            endcase
        end
        if (startCycle) begin
            next_cur.writeStart = 1'b1;
            next_cur.cycleAddr = cur.tablePointer;
            next_cur.cycle = regWriteData[`FSW_CTL_ERASE] ? FSW_ERASE : FSW_PROGRAM;
        end
        if (timerDone) begin
            next_cur.writeStart = 1'b0;
            next_cur.cycle = FSW_READY;
            next_cur.irqStatus[`FSW_IRQ_DONE] = 1'b1;
        end
        if (cur.faultPending) begin
            // set wins over a clear in the same cycle
            next_cur.programFaultFlag = 1'b1;
            next_cur.irqStatus[`FSW_IRQ_FAULT] = 1'b1;
            next_cur.faultPending = 1'b0;
        end
        next_cur.readData = 8'h00;
        if (regRead) begin
            case (regAddr)
                `FSW_ADDR_PTR_UPPER: next_cur.readData = {2'b00, cur.tablePointer[21:16]};
                `FSW_ADDR_PTR_HIGH: next_cur.readData = cur.tablePointer[15:8];
                `FSW_ADDR_PTR_LOW: next_cur.readData = cur.tablePointer[7:0];
                `FSW_ADDR_LATCH: next_cur.readData = cur.tableLatchByte;
                `FSW_ADDR_CONTROL: next_cur.readData = ctlByte(cur);
                `FSW_ADDR_IRQ_STATUS: next_cur.readData = {6'h00, cur.irqStatus};
                `FSW_ADDR_IRQ_MASK: next_cur.readData = {6'h00, cur.irqMask};
                `FSW_ADDR_HOLD_INDEX: next_cur.readData = {2'b00, cur.holdIndex};
                `FSW_ADDR_HOLD_DATA: next_cur.readData = cur.holding[cur.holdIndex];
                default: next_cur.readData = 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            cur <= '0;
            // holding bytes survive reset; the fault flag only a fault reset
            cur.programFaultFlag <= next_cur.programFaultFlag && faultReset;
            cur.holding <= next_cur.holding;
            cur.faultPending <= faultReset && timerBusy;
        end else begin
            cur <= next_cur;
        end
    end

    assign regReadData = cur.readData;
    assign cpuStall = cur.cycle != FSW_READY;
    assign flashProgram = cur.cycle == FSW_PROGRAM;
    assign flashErase = cur.cycle == FSW_ERASE;
    assign flashAddr = flashErase ? {cur.cycleAddr[21:10], 10'h000}
        : {cur.cycleAddr[21:6], 6'h00};
    assign flashDataIndex = cur.holdIndex;
    assign flashData = cur.holding[cur.holdIndex];
    assign irq = |(cur.irqStatus & cur.irqMask);

    chk_stall_span: assert property (@(posedge core_clk) disable iff (reset)
        startCycle |=> cpuStall && cur.writeStart)
        else $error("cycle start did not stall the cpu");
    chk_start_clear: assert property (@(posedge core_clk) disable iff (reset)
        timerDone |=> !cur.writeStart && !cpuStall)
        else $error("write start not cleared at cycle end");
    chk_erase_select: assert property (@(posedge core_clk) disable iff (reset)
        startCycle && regWriteData[`FSW_CTL_ERASE] |=> flashErase && !flashProgram)
        else $error("erase not selected");
    chk_preinc_store: assert property (@(posedge core_clk) disable iff (reset)
        regWrite && regAddr == `FSW_ADDR_STORE && cur.cycle == FSW_READY
        |=> cur.tablePointer == $past(cur.tablePointer) + 22'h1
        && cur.holding[cur.tablePointer[5:0]] == $past(cur.tableLatchByte))
        else $error("store did not pre-increment and latch");
    chk_no_enable: assert property (@(posedge core_clk) disable iff (reset)
        wrCtl && !regWriteData[`FSW_CTL_ENABLE] && cur.cycle == FSW_READY |=> !cpuStall)
        else $error("cycle started without enable");
    chk_ctl_zero: assert property (@(posedge core_clk) disable iff (reset)
        $past(regRead) && $past(regAddr) == `FSW_ADDR_CONTROL |-> regReadData[7:5] == 3'b000
        && regReadData[0] == 1'b0)
        else $error("unimplemented control bits not zero");
    chk_ptr_upper: assert property (@(posedge core_clk) disable iff (reset)
        $past(regRead) && $past(regAddr) == `FSW_ADDR_PTR_UPPER
        |-> regReadData == {2'b00, $past(cur.tablePointer[21:16])})
        else $error("pointer upper byte read back wrong");

    chk_stall_hold: assert property (@(posedge core_clk) disable iff (reset)
        cpuStall && !timerDone |=> cpuStall)
        else $error("stall ended before the timer");

    chk_stall_entry: assert property (@(posedge core_clk) disable iff (reset)
        $rose(cpuStall) |-> $past(armed) && $past(wrCtl))
        else $error("stall began without unlock and control write");

    chk_row_addr: assert property (@(posedge core_clk) disable iff (reset)
        startCycle && regWriteData[`FSW_CTL_ERASE]
        |=> flashAddr[21:10] == $past(cur.tablePointer[21:10])
        && flashAddr[9:0] == 10'h000)
        else $error("erase address not the pointer row");

    chk_block_addr: assert property (@(posedge core_clk) disable iff (reset)
        startCycle && !regWriteData[`FSW_CTL_ERASE]
        |=> flashAddr == {$past(cur.tablePointer[21:6]), 6'h00})
        else $error("program address not the pointer block");

    chk_ctl_write: assert property (@(posedge core_clk) disable iff (reset)
        wrCtl |=> cur.programEnable == $past(regWriteData[`FSW_CTL_ENABLE])
        && cur.eraseSelect == $past(regWriteData[`FSW_CTL_ERASE]))
        else $error("control write did not update enable and erase");

    chk_key_empty: assert property (@(posedge core_clk) disable iff (reset)
        $past(regRead) && $past(regAddr) == `FSW_ADDR_KEY |-> regReadData == 8'h00)
        else $error("key register returned data");

    chk_hold_keep: assert property (@(posedge core_clk) disable iff (reset)
        timerDone |=> cur.holding == $past(cur.holding))
        else $error("holding registers changed at cycle end");

    chk_irq_done: assert property (@(posedge core_clk) disable iff (reset)
        timerDone |=> cur.irqStatus[`FSW_IRQ_DONE])
        else $error("cycle end did not set the done status");

    chk_fault_pending: assert property (@(posedge core_clk)
        reset && faultReset && timerBusy |=> cur.faultPending)
        else $error("interrupted cycle not recorded");
    chk_fault_flag: assert property (@(posedge core_clk) disable iff (reset)
        cur.faultPending |=> cur.programFaultFlag && cur.irqStatus[`FSW_IRQ_FAULT])
        else $error("fault flag not set after interrupted cycle");
    cov_refused: cover property (@(posedge core_clk) disable iff (reset)
        wrCtl && regWriteData[`FSW_CTL_START] && !startCycle);
    cov_program: cover property (@(posedge core_clk) disable iff (reset)
        startCycle && !regWriteData[`FSW_CTL_ERASE]);
    cov_erase: cover property (@(posedge core_clk) disable iff (reset) $rose(flashErase));
    cov_fault: cover property (@(posedge core_clk) $rose(cur.programFaultFlag));
endmodule

//--- tb/fsw_core_model.sv
// Purpose: processor core issuing register accesses to the flash writer
// Assumes: every access is called just after a rising clock edge
// Notes: strobes stay up between back-to-back accesses; rel drops them
`timescale 1ns/1ps
module fsw_core_model (
    input wire logic core_clk,
    output logic [3:0] regAddr,
    output logic [7:0] regWriteData,
    output logic regWrite,
    output logic regRead
);
    initial begin
        regAddr = 4'h0;
        regWriteData = 8'h00;
        regWrite = 1'b0;
        regRead = 1'b0;
    end

    // one access: held until the edge that takes it
    task automatic access(input logic [3:0] a, input logic [7:0] d, input logic w);
        regAddr <= a;
        regWriteData <= d;
        regWrite <= w;
        regRead <= ~w;
        @(posedge core_clk);
    endtask

    task automatic rel();
        regWrite <= 1'b0;
        regRead <= 1'b0;
    endtask
endmodule

//--- tb/testbench.sv
// Purpose: self-checking bench for the flash self-program writer
// Assumes: short write timer of 8 cycles
// Notes: read results are checked against a queue of expected bytes
`timescale 1ns/1ps
`include "fsw_params.svh"
module testbench;
    localparam int WC = 8;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic faultReset = 1'b0;
    logic [3:0] regAddr;
    logic [7:0] regWriteData, regReadData;
    logic regWrite, regRead, cpuStall, flashProgram, flashErase, irq;
    logic [21:0] flashAddr;
    logic [7:0] flashData;
    logic [5:0] flashDataIndex;
    logic [15:0] expQ[$];
    logic rdPend = 1'b0;
    logic [7:0] hold[64];
    logic [31:0] seed = 32'hbaf9;
    logic [23:0] bad[3] = '{24'haa5506, 24'h55aa02, 24'h000006};
    logic [21:0] gAddr;
    logic gProg, gErase;
    int gN;
    int nMismatch = 0;
    int checks = 0;

    always #5 core_clk = ~core_clk;

    fsw_core_model core (.core_clk(core_clk), .regAddr(regAddr),
        .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead));

    fsw_top #(.WRITE_CYCLES(WC)) DUT (.core_clk(core_clk), .reset(reset),
        .faultReset(faultReset), .regAddr(regAddr), .regWriteData(regWriteData),
        .regWrite(regWrite), .regRead(regRead), .regReadData(regReadData),
        .cpuStall(cpuStall), .flashProgram(flashProgram), .flashErase(flashErase),
        .flashAddr(flashAddr), .flashData(flashData), .flashDataIndex(flashDataIndex),
        .irq(irq));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            nMismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, nMismatch);
        if (nMismatch == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // read data stands only in the cycle after the strobe
    always @(posedge core_clk) rdPend <= regRead;
    always @(negedge core_clk) begin
        logic [15:0] f;
        if (rdPend === 1'b1) begin
            f = (expQ.size() > 0) ? expQ.pop_front() : 16'hffff;
            check("readData", 32'(regReadData & f[15:8]), 32'(f[7:0] & f[15:8]));
        end
    end

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        core.access(a, d, 1'b1);
    endtask

    task automatic rdx(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
        expQ.push_back({m, e});
        core.access(a, 8'h00, 1'b0);
    endtask

    task automatic ptr(input logic [7:0] u, input logic [7:0] h, input logic [7:0] l);
        wr(`FSW_ADDR_PTR_UPPER, u);
        wr(`FSW_ADDR_PTR_HIGH, h);
        wr(`FSW_ADDR_PTR_LOW, l);
    endtask

    // key pair, control write, then measure the stall
    task automatic go(input logic [7:0] k1, input logic [7:0] k2, input logic [7:0] c);
        wr(`FSW_ADDR_KEY, k1);
        wr(`FSW_ADDR_KEY, k2);
        wr(`FSW_ADDR_CONTROL, c);
        core.rel();
        gN = 0;
        for (int i = 0; i < WC + 8; i++) begin
            @(negedge core_clk);
            if (i == 0) begin
                gAddr = flashAddr;
                gProg = flashProgram;
                gErase = flashErase;
            end
            if (cpuStall === 1'b1)
                gN++;
        end
        @(posedge core_clk);
    endtask

    initial begin
        repeat (5000) @(posedge core_clk);
        nMismatch++;
        summarize();
    end

    initial begin
        repeat (8) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        rdx(`FSW_ADDR_CONTROL, 8'h00, 8'hff);
        wr(`FSW_ADDR_KEY, 8'h55);
        rdx(`FSW_ADDR_KEY, 8'h00, 8'hff);
        ptr(8'hff, 8'hab, 8'hcd);
        rdx(`FSW_ADDR_PTR_UPPER, 8'h3f, 8'hff);
        rdx(`FSW_ADDR_PTR_HIGH, 8'hab, 8'hff);
        rdx(`FSW_ADDR_PTR_LOW, 8'hcd, 8'hff);
        wr(`FSW_ADDR_IRQ_MASK, 8'h00);
        go(8'h55, 8'haa, 8'h16);
        // stall covers the timer run and its done cycle
        check("eraseLen", 32'(gN), 32'(WC + 1));
        check("erase", 32'(gErase), 32'd1);
        check("eraseProg", 32'(gProg), 32'd0);
        check("eraseAddr", 32'(gAddr), 32'h3fa800);
        check("irqMasked", 32'(irq), 32'd0);
        rdx(`FSW_ADDR_IRQ_STATUS, 8'h01, 8'h01);
        rdx(`FSW_ADDR_CONTROL, 8'h14, 8'hff);
        wr(`FSW_ADDR_IRQ_STATUS, 8'h01);
        wr(`FSW_ADDR_CONTROL, 8'h00);
        ptr(8'h3f, 8'ha7, 8'hff);
        for (int b = 0; b < 16; b++) begin
            for (int i = 0; i < 64; i++) begin
                seed = lfsr(seed);
                hold[i] = seed[7:0];
                wr(`FSW_ADDR_LATCH, hold[i]);
                wr(`FSW_ADDR_STORE, 8'h00);
            end
            if (b == 0) begin
                rdx(`FSW_ADDR_PTR_LOW, 8'h3f, 8'hff);
                rdx(`FSW_ADDR_LATCH, hold[63], 8'hff);
                for (int k = 0; k < 3; k++) begin
                    go(bad[k][23:16], bad[k][15:8], bad[k][7:0]);
                    check("refusedStall", 32'(gN), 32'd0);
                end
                wr(`FSW_ADDR_IRQ_MASK, 8'h01);
            end
            go(8'h55, 8'haa, 8'h06);
            check("progLen", 32'(gN), 32'(WC + 1));
            check("program", 32'(gProg), 32'd1);
            check("progErase", 32'(gErase), 32'd0);
            check("progAddr", 32'(gAddr), 32'(22'h3fa800 + 22'(64 * b)));
            check("irqSet", 32'(irq), 32'd1);
            wr(`FSW_ADDR_IRQ_STATUS, 8'h01);
            core.rel();
            @(negedge core_clk);
            check("irqClear", 32'(irq), 32'd0);
            @(posedge core_clk);
        end
        for (int i = 0; i < 64; i++) begin
            wr(`FSW_ADDR_HOLD_INDEX, 8'(i));
            rdx(`FSW_ADDR_HOLD_DATA, hold[i], 8'hff);
            check("flashData", 32'(flashData), 32'(hold[i]));
            check("flashIndex", 32'(flashDataIndex), 32'(i));
        end
        wr(`FSW_ADDR_CONTROL, 8'h00);
        wr(`FSW_ADDR_KEY, 8'h55);
        wr(`FSW_ADDR_KEY, 8'haa);
        wr(`FSW_ADDR_CONTROL, 8'h06);
        core.rel();
        repeat (3) @(posedge core_clk);
        reset <= 1'b1;
        faultReset <= 1'b1;
        @(posedge core_clk);
        reset <= 1'b0;
        faultReset <= 1'b0;
        #1;
        check("stallReset", 32'(cpuStall), 32'd0);
        repeat (3) @(posedge core_clk);
        rdx(`FSW_ADDR_CONTROL, 8'h08, 8'h08);
        rdx(`FSW_ADDR_IRQ_STATUS, 8'h02, 8'h02);
        wr(`FSW_ADDR_CONTROL, 8'h00);
        rdx(`FSW_ADDR_CONTROL, 8'h00, 8'hff);
        core.rel();
        repeat (3) @(posedge core_clk);
        check("queueEmpty", 32'(expQ.size()), 32'd0);
        summarize();
    end
endmodule
